// ==== core/dtcm_pkg.sv ====
// ==========================================================================
// shared constants of the dual timer/counter block
// ==========================================================================
package dtcm_pkg;

  // ========================================================================
  // special function register addresses
  // ========================================================================
  localparam logic [7:0] ADDR_CTRL_FLAG = 8'h88;  // timer_ctrl_flag_reg
  localparam logic [7:0] ADDR_MODE      = 8'h89;  // timer_mode_reg
  localparam logic [7:0] ADDR_CLO_ZERO  = 8'h8a;  // count_low_zero
  localparam logic [7:0] ADDR_CLO_ONE   = 8'h8b;  // count_low_one
  localparam logic [7:0] ADDR_CHI_ZERO  = 8'h8c;  // count_high_zero
  localparam logic [7:0] ADDR_CHI_ONE   = 8'h8d;  // count_high_one
  localparam logic [7:0] ADDR_RATE      = 8'h8e;  // clock_rate_reg

  // ========================================================================
  // reset values
  // ========================================================================
  localparam logic [7:0] RST_MODE  = 8'h00;
  localparam logic [3:0] RST_CTRL  = 4'h0;        // upper nibble only
  localparam logic [7:0] RST_RATE  = 8'h01;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;       // unmapped / reserved

  // ========================================================================
  // field positions
  // ========================================================================
  localparam int CTRL_OVF_ONE  = 7;  // overflow_flag_one
  localparam int CTRL_RUN_ONE  = 6;  // run_bit_one
  localparam int CTRL_OVF_ZERO = 5;  // overflow_flag_zero
  localparam int CTRL_RUN_ZERO = 4;  // run_bit_zero
  localparam int MODE_GATE_ONE = 7;
  localparam int MODE_CT_ONE   = 6;
  localparam int MODE_HI_ONE   = 5;  // mode_hi_bit, timer 1
  localparam int MODE_LO_ONE   = 4;  // mode_lo_bit, timer 1
  localparam int MODE_GATE_ZRO = 3;
  localparam int MODE_CT_ZRO   = 2;
  localparam int MODE_HI_ZRO   = 1;
  localparam int MODE_LO_ZRO   = 0;
  localparam int RATE_SEL_ONE  = 4;  // rate_select_one
  localparam int RATE_SEL_ZERO = 3;  // rate_select_zero
  localparam int EVT_BIT_ZERO  = 5;  // event_pin_zero on port 0
  localparam int EVT_BIT_ONE   = 6;  // event_pin_one on port 0

  // ========================================================================
  // counting modes
  // ========================================================================
  typedef logic [1:0] dtcm_mode_t;
  localparam dtcm_mode_t MODE_13BIT  = 2'h0;
  localparam dtcm_mode_t MODE_16BIT  = 2'h1;
  localparam dtcm_mode_t MODE_RELOAD = 2'h2;
  localparam dtcm_mode_t MODE_SPLIT  = 2'h3;

  // ========================================================================
  // prescaler: one counter 0..11 yields both /12 and /4 ticks
  // ========================================================================
  localparam logic [3:0] PRESC_LAST = 4'hb;       // divide by 12
  localparam logic [3:0] PRESC_ZERO = 4'h0;
  localparam logic [1:0] QUART_LAST = 2'h3;       // divide by 4
  localparam logic [4:0] LOW5_ALL   = 5'h1f;      // 13 bit low part full
  localparam logic [7:0] BYTE_ALL   = 8'hff;

endpackage : dtcm_pkg

// ==== core/dtcm_timers.sv ====
// Behaviour
// - timer from clock or event pin counter
// - event inputs on port 0 bits 5,6
// - 16 bit count as two byte registers
// - four modes, control and flags register
// - mode field: 13, 16, reload, split
// - split mode applies to timer 0 only
// - mode bits 7..4 steer timer 1
// - mode bits 3..0 steer timer 0
// - timer 1 gated: run and pin high
// - timer 1 ungated: run bit alone
// - timer 1 clock /4, /12 or pin
// - timer 0 gating by run and pin
// - timer 0 clock /4, /12 or pin
// - 13 bit wrap sets flag, pulses output
// - 16 bit wraps from all ones
// - reload mode reloads low from high
// - split: high byte uses timer 1 bits
`timescale 1ns/100ps

module dtcm_timers
  import dtcm_pkg::*;
(
  input  wire logic       CLK,               // cpu clock, 25 MHz
  input  wire logic       RST,               // asynchronous, active high
  input  wire logic [7:0] SFR_ADDR,          // register address
  input  wire logic [7:0] SFR_WDATA,         // write data
  input  wire logic       SFR_WE,            // write strobe, one cycle
  input  wire logic       SFR_RE,            // read strobe, one cycle
  output logic      [7:0] SFR_RDATA,         // read data, a cycle after strobe
  input  wire logic [7:0] PORT0_IN,          // port 0 pin levels
  input  wire logic       EXT_IRQ_PIN_ZERO_N,// gate input of timer 0
  input  wire logic       EXT_IRQ_PIN_ONE_N, // gate input of timer 1
  input  wire logic       FLAG_ACK_ZERO,     // vectoring clears flag 0
  input  wire logic       FLAG_ACK_ONE,      // vectoring clears flag 1
  output logic            OVF_FLAG_ZERO,     // overflow flag of timer 0
  output logic            OVF_FLAG_ONE,      // overflow flag of timer 1
  output logic            OVF_PULSE_ZERO,    // one-cycle wrap pulse
  output logic            OVF_PULSE_ONE      // one-cycle wrap pulse
);

  // ==========================================================================
  // step function shared by both timers in modes 0 to 2
  // ==========================================================================
  // returns {overflow, high, low}; split mode holds, used for timer 1 stop
  function automatic logic [16:0] timer_step(input dtcm_mode_t mode,
                                             input logic [7:0] hi,
                                             input logic [7:0] lo,
                                             input logic       inc);
    logic [16:0] res;
    res = {1'b0, hi, lo};
    if (inc)
    begin
      unique case (mode)
        // five low bits then the high byte
        MODE_13BIT:
        begin
          res[4:0] = lo[4:0] + 5'h01;
          if (lo[4:0] == LOW5_ALL)
          begin
            res[15:8] = hi + 8'h01;
            res[16]   = (hi == BYTE_ALL);
          end
        end
        MODE_16BIT:
        begin
          res[7:0] = lo + 8'h01;
          if (lo == BYTE_ALL)
          begin
            res[15:8] = hi + 8'h01;
            res[16]   = (hi == BYTE_ALL);
          end
        end
        // low byte reloads from high byte
        MODE_RELOAD:
        begin
          res[7:0] = (lo == BYTE_ALL) ? hi : lo + 8'h01;
          res[16]  = (lo == BYTE_ALL);
        end
        MODE_SPLIT:
        begin
          res = {1'b0, hi, lo};
        end
      endcase
    end
    return res;
  endfunction : timer_step

  // ==========================================================================
  // prescaler
  // ==========================================================================
  logic [3:0] presc_ff;     // 0..11 cpu clock counter
  logic [3:0] nxt_presc;
  logic       tick12;       // one-cycle pulse every 12 clocks
  logic       tick4;        // one-cycle pulse every 4 clocks

  // free-running divider; both rates come from one counter so they align
  always_comb
  begin
    nxt_presc = (presc_ff == PRESC_LAST) ? PRESC_ZERO : presc_ff + 4'h1;
    tick12    = (presc_ff == PRESC_LAST);
    tick4     = (presc_ff[1:0] == QUART_LAST);
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      presc_ff <= PRESC_ZERO;
    else
      presc_ff <= nxt_presc;
  end

  // ==========================================================================
  // event pin synchroniser and falling edge detect
  // ==========================================================================
  logic [1:0] ev_meta_ff;   // first stage, read only by second stage
  logic [1:0] ev_sync_ff;   // second stage
  logic [1:0] ev_prev_ff;   // previous synchronised level
  logic [1:0] nxt_ev_meta;
  logic [1:0] ev_fall;      // one pulse per high-to-low transition

  // event pins are port 0 bits 5 and 6
  always_comb
  begin
    nxt_ev_meta = {PORT0_IN[EVT_BIT_ONE], PORT0_IN[EVT_BIT_ZERO]};
    ev_fall     = ev_prev_ff & ~ev_sync_ff;
  end

  // pins idle high at reset so no false edge is seen on release
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      ev_meta_ff <= 2'h3;
      ev_sync_ff <= 2'h3;
      ev_prev_ff <= 2'h3;
    end
    else
    begin
      ev_meta_ff <= nxt_ev_meta;
      ev_sync_ff <= ev_meta_ff;
      ev_prev_ff <= ev_sync_ff;
    end
  end

  // ==========================================================================
  // registers and counters
  // ==========================================================================
  logic [7:0] mode_ff;      // timer_mode_reg
  logic [3:0] ctrl_ff;      // timer_ctrl_flag_reg bits 7..4
  logic [7:0] rate_ff;      // clock_rate_reg
  logic [7:0] clo0_ff;      // count_low_zero
  logic [7:0] chi0_ff;      // count_high_zero
  logic [7:0] clo1_ff;      // count_low_one
  logic [7:0] chi1_ff;      // count_high_one
  logic       pulse0_ff;    // wrap pulse timer 0
  logic       pulse1_ff;    // wrap pulse timer 1
  logic [7:0] rdata_ff;     // read data holding
  logic [7:0] nxt_mode;
  logic [3:0] nxt_ctrl;
  logic [7:0] nxt_rate;
  logic [7:0] nxt_clo0;
  logic [7:0] nxt_chi0;
  logic [7:0] nxt_clo1;
  logic [7:0] nxt_chi1;
  logic       nxt_pulse0;
  logic       nxt_pulse1;
  logic [7:0] nxt_rdata;
  dtcm_mode_t mode0;        // timer 0 mode field
  dtcm_mode_t mode1;        // timer 1 mode field
  logic       run0;         // run_bit_zero
  logic       run1;         // run_bit_one
  logic       div0;         // divided clock tick for timer 0
  logic       div1;         // divided clock tick for timer 1
  logic       inc0;         // timer 0 (or low byte in split) advances
  logic       inc1;         // timer 1 advances
  logic       inc0_hi;      // split high byte advances
  logic       ovf0;         // wrap events this cycle
  logic       ovf1;
  logic       ovf0_hi;
  logic [16:0] step0;
  logic [16:0] step1;
  logic [7:0]  lo_split;    // split-mode low byte next
  logic [7:0]  hi_split;    // split-mode high byte next

  // counting, flags and software access; software write beats a count step
  always_comb
  begin
    mode0 = mode_ff[MODE_HI_ZRO:MODE_LO_ZRO];
    mode1 = mode_ff[MODE_HI_ONE:MODE_LO_ONE];
    run0  = ctrl_ff[CTRL_RUN_ZERO - 4];
    run1  = ctrl_ff[CTRL_RUN_ONE - 4];
    // divide by 4 when rate select set, else 12
    div0  = rate_ff[RATE_SEL_ZERO] ? tick4 : tick12;
    div1  = rate_ff[RATE_SEL_ONE] ? tick4 : tick12;
    // gate needs pin high as well as run
    // counter/timer select picks pin or divider
    inc0  = run0 & (~mode_ff[MODE_GATE_ZRO] | EXT_IRQ_PIN_ZERO_N)
                 & (mode_ff[MODE_CT_ZRO] ? ev_fall[0] : div0);
    // gated timer 1 needs pin high
    // ungated timer 1 ignores the pin
    inc1  = run1 & (~mode_ff[MODE_GATE_ONE] | EXT_IRQ_PIN_ONE_N)
                 & (mode_ff[MODE_CT_ONE] ? ev_fall[1] : div1);
    // split high byte counts divided clock under run_bit_one
    inc0_hi = run1 & div0;

    // decode the mode field per timer
    step0    = timer_step(mode0, chi0_ff, clo0_ff, inc0);
    // timer 1 in split value only holds its count
    step1    = timer_step(mode1, chi1_ff, clo1_ff, inc1);
    lo_split = clo0_ff + (inc0 ? 8'h01 : 8'h00);
    hi_split = chi0_ff + (inc0_hi ? 8'h01 : 8'h00);

    // split mode reuses timer 1 flag for the high byte
    if (mode0 == MODE_SPLIT)
    begin
      nxt_clo0 = lo_split;
      nxt_chi0 = hi_split;
      ovf0     = inc0 & (clo0_ff == BYTE_ALL);
      ovf0_hi  = inc0_hi & (chi0_ff == BYTE_ALL);
    end
    else
    begin
      nxt_clo0 = step0[7:0];
      nxt_chi0 = step0[15:8];
      ovf0     = step0[16];
      ovf0_hi  = 1'b0;
    end
    nxt_clo1 = step1[7:0];
    nxt_chi1 = step1[15:8];
    ovf1     = step1[16];

    // output pulse for one clock on wrap
    nxt_pulse0 = ovf0;
    nxt_pulse1 = ovf1;

    nxt_mode = mode_ff;
    nxt_rate = rate_ff;
    nxt_ctrl = ctrl_ff;

    // flag clear by vectoring, run or clear by software write
    if (FLAG_ACK_ZERO)
      nxt_ctrl[CTRL_OVF_ZERO - 4] = 1'b0;
    if (FLAG_ACK_ONE)
      nxt_ctrl[CTRL_OVF_ONE - 4] = 1'b0;

    // byte-wide software access to counts and settings
    if (SFR_WE)
    begin
      unique case (SFR_ADDR)
        ADDR_CTRL_FLAG: nxt_ctrl = SFR_WDATA[7:4];
        ADDR_MODE:      nxt_mode = SFR_WDATA;
        ADDR_RATE:      nxt_rate = SFR_WDATA;
        ADDR_CLO_ZERO:  nxt_clo0 = SFR_WDATA;
        ADDR_CHI_ZERO:  nxt_chi0 = SFR_WDATA;
        ADDR_CLO_ONE:   nxt_clo1 = SFR_WDATA;
        ADDR_CHI_ONE:   nxt_chi1 = SFR_WDATA;
        default:        nxt_mode = mode_ff;  // other addresses not ours
      endcase
    end

    // hardware set wins over any clear in the same cycle
    if (ovf0)
      nxt_ctrl[CTRL_OVF_ZERO - 4] = 1'b1;
    // in split mode the high byte owns flag 1, timer 1 does not
    if (ovf0_hi | (ovf1 & (mode0 != MODE_SPLIT)))
      nxt_ctrl[CTRL_OVF_ONE - 4] = 1'b1;

    // read mux; unmapped and reserved bits read zero
    nxt_rdata = rdata_ff;
    if (SFR_RE)
    begin
      unique case (SFR_ADDR)
        ADDR_CTRL_FLAG: nxt_rdata = {ctrl_ff, 4'h0};
        ADDR_MODE:      nxt_rdata = mode_ff;
        ADDR_RATE:      nxt_rdata = rate_ff;
        ADDR_CLO_ZERO:  nxt_rdata = clo0_ff;
        ADDR_CHI_ZERO:  nxt_rdata = chi0_ff;
        ADDR_CLO_ONE:   nxt_rdata = clo1_ff;
        ADDR_CHI_ONE:   nxt_rdata = chi1_ff;
        default:        nxt_rdata = READ_ZERO;
      endcase
    end
  end

  // state registers
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      mode_ff   <= RST_MODE;
      ctrl_ff   <= RST_CTRL;
      rate_ff   <= RST_RATE;
      clo0_ff   <= RST_COUNT;
      chi0_ff   <= RST_COUNT;
      clo1_ff   <= RST_COUNT;
      chi1_ff   <= RST_COUNT;
      pulse0_ff <= 1'b0;
      pulse1_ff <= 1'b0;
      rdata_ff  <= READ_ZERO;
    end
    else
    begin
      mode_ff   <= nxt_mode;
      ctrl_ff   <= nxt_ctrl;
      rate_ff   <= nxt_rate;
      clo0_ff   <= nxt_clo0;
      chi0_ff   <= nxt_chi0;
      clo1_ff   <= nxt_clo1;
      chi1_ff   <= nxt_chi1;
      pulse0_ff <= nxt_pulse0;
      pulse1_ff <= nxt_pulse1;
      rdata_ff  <= nxt_rdata;
    end
  end

  // ==========================================================================
  // outputs, all from flip-flops
  // ==========================================================================
  assign SFR_RDATA      = rdata_ff;
  assign OVF_FLAG_ZERO  = ctrl_ff[CTRL_OVF_ZERO - 4];
  assign OVF_FLAG_ONE   = ctrl_ff[CTRL_OVF_ONE - 4];
  assign OVF_PULSE_ZERO = pulse0_ff;
  assign OVF_PULSE_ONE  = pulse1_ff;

endmodule : dtcm_timers

// ==== tb/dtcm_timers_sva.sv ====
`timescale 1ns/100ps
// ==========================================================================
// port checks of the timer block
module dtcm_chk
  import dtcm_pkg::*;
(
  input wire logic       CLK,             // cpu clock
  input wire logic       RST,             // asynchronous, active high
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic       SFR_WE,
  input wire logic       SFR_RE,
  input wire logic [7:0] SFR_RDATA,
  input wire logic       FLAG_ACK_ZERO,
  input wire logic       FLAG_ACK_ONE,
  input wire logic       OVF_FLAG_ZERO,
  input wire logic       OVF_FLAG_ONE,
  input wire logic       OVF_PULSE_ZERO
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  // software may set or clear flags itself, so such cycles are excluded
  wire ctl_wr   = SFR_WE && SFR_ADDR == ADDR_CTRL_FLAG;
  wire unmapped = SFR_ADDR < ADDR_CTRL_FLAG || SFR_ADDR > ADDR_RATE;

  a_pulse_one_clk: assert property (
    OVF_PULSE_ZERO |=> !OVF_PULSE_ZERO) else $error("wrap pulse longer than a clock");
  // flag and pulse are both registered on the edge that wraps the count
  a_wrap_then_pulse: assert property (
    $rose(OVF_FLAG_ZERO) && !$past(SFR_WE) |-> OVF_PULSE_ZERO) else $error("no wrap pulse");
  // a wrap beats a clear in the same cycle, so the pulse always has its flag
  a_pulse_has_flag: assert property (
    OVF_PULSE_ZERO |-> OVF_FLAG_ZERO) else $error("pulse without flag");
  // a fresh wrap on the ack edge re-sets the flag and shows its pulse together
  a_ack_clears: assert property (
    FLAG_ACK_ZERO && !ctl_wr |=> !OVF_FLAG_ZERO || OVF_PULSE_ZERO)
    else $error("flag zero not cleared by ack");
  a_flag_holds: assert property (
    OVF_FLAG_ONE && !FLAG_ACK_ONE && !ctl_wr |=> OVF_FLAG_ONE) else $error("flag one lost");
  a_ctl_read: assert property (
    SFR_RE && SFR_ADDR == ADDR_CTRL_FLAG |=> SFR_RDATA[3:0] == 4'h0
      && SFR_RDATA[5] == $past(OVF_FLAG_ZERO) && SFR_RDATA[7] == $past(OVF_FLAG_ONE))
    else $error("control read wrong");
  a_unmapped_zero: assert property (
    SFR_RE && unmapped |=> SFR_RDATA == READ_ZERO) else $error("unmapped read not zero");
  a_rdata_holds: assert property (
    !SFR_RE |=> $stable(SFR_RDATA)) else $error("read data moved without a read");
  a_mode_readback: assert property (
    SFR_WE && SFR_ADDR == ADDR_MODE ##1 !SFR_WE ##1 SFR_RE && !SFR_WE && SFR_ADDR == ADDR_MODE
    |=> SFR_RDATA == $past(SFR_WDATA, 3)) else $error("mode readback wrong");
endmodule : dtcm_chk

bind dtcm_timers dtcm_chk u_chk (
  .CLK(CLK), .RST(RST), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA), .SFR_WE(SFR_WE),
  .SFR_RE(SFR_RE), .SFR_RDATA(SFR_RDATA), .FLAG_ACK_ZERO(FLAG_ACK_ZERO),
  .FLAG_ACK_ONE(FLAG_ACK_ONE), .OVF_FLAG_ZERO(OVF_FLAG_ZERO), .OVF_FLAG_ONE(OVF_FLAG_ONE),
  .OVF_PULSE_ZERO(OVF_PULSE_ZERO));

// ==== tb/dtcm_pins.sv ====
`timescale 1ns/100ps
// ==========================================================================
// event pin source standing in for the outside world
module dtcm_pins
(
  input  wire logic       clk,    // cpu clock
  input  wire logic       start,  // begin a burst
  input  wire logic [3:0] n,      // falling edges in the burst
  input  wire logic       slow,   // stretch each level
  output logic            ev,     // event pin, idles high
  output logic            busy    // burst in progress
);
  initial
  begin
    ev   = 1'b1;
    busy = 1'b0;
  end
  // levels held 3 or 6 clocks, well past the synchroniser
  always
  begin
    @(posedge clk);
    if (start)
    begin
      busy <= 1'b1;
      for (int i = 0; i < n; i++)
      begin
        ev <= 1'b0;
        repeat (slow ? 6 : 3) @(posedge clk);
        ev <= 1'b1;
        repeat (slow ? 6 : 3) @(posedge clk);
      end
      busy <= 1'b0;
    end
  end
endmodule : dtcm_pins

// ==== tb/tb_dual_timer_counter_modes.sv ====
`timescale 1ns/100ps
// ==========================================================================
// self-checking bench of the dual timer/counter block
module tb_dual_timer_counter_modes;
  import dtcm_pkg::*;
  logic       clk, rst, we, re, ack0, ack1, irq0, irq1, start, slow, tsel, ev, busy;
  logic       f0, f1, p0, p1;
  logic [7:0] addr, wd, rdata, port0, v;
  logic [3:0] n_ev;
  int         failures, comparisons, cyc;
  // only the pin of the timer under test carries events
  assign port0 = {1'b1, tsel ? ev : 1'b1, tsel ? 1'b1 : ev, 5'h1f};
  dtcm_timers DUT (.CLK(clk), .RST(rst), .SFR_ADDR(addr), .SFR_WDATA(wd), .SFR_WE(we),
    .SFR_RE(re), .SFR_RDATA(rdata), .PORT0_IN(port0), .EXT_IRQ_PIN_ZERO_N(irq0),
    .EXT_IRQ_PIN_ONE_N(irq1), .FLAG_ACK_ZERO(ack0), .FLAG_ACK_ONE(ack1),
    .OVF_FLAG_ZERO(f0), .OVF_FLAG_ONE(f1), .OVF_PULSE_ZERO(p0), .OVF_PULSE_ONE(p1));
  dtcm_pins u_pins (.clk(clk), .start(start), .n(n_ev), .slow(slow), .ev(ev), .busy(busy));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      end_sim();
    end
  end
  // ========================================================================
  // bus tasks and reference model
  task automatic end_sim;
    $display("comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd   <= d;
    we   <= 1'b1;
    @(posedge clk);
    we   <= 1'b0;
  endtask : wr
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch at %0t: got %h, expected %h", $time, g, e);
    end
  endtask : chk
  // read data lands one edge after the strobe
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    re   <= 1'b1;
    @(posedge clk);
    re   <= 1'b0;
    #1 chk(rdata, e);
  endtask : rchk
  // one increment: returns {overflow, high, low}
  function automatic int step(input int md, input int lo, input int hi);
    int x;
    x = (md == 0) ? (hi * 32 + lo % 32 + 1) % 8192 : (hi * 256 + lo + 1) % 65536;
    if (md == 0)
      return (x == 0 ? 65536 : 0) | (x / 32) << 8 | (lo & 224) | (x % 32);
    if (md == 1)
      return (x == 0 ? 65536 : 0) | x;
    if (md == 2)
      return lo == 255 ? 65536 | hi << 8 | hi : hi << 8 | lo + 1;
    return hi << 8 | lo;
  endfunction : step
  // event counting: the model steps once per delivered falling edge
  task automatic ev_test(input int t, md, g, pin, lo, hi, n);
    int r, el, eh, ov;
    el = lo;
    eh = hi;
    ov = 0;
    wr(ADDR_MODE, t ? 8'(g * 128 + 64 + md * 16) : 8'(g * 8 + 4 + md));
    // wr returns on a rising edge, so pin routing and gates change there
    tsel <= t[0];
    slow <= t[0];
    irq0 <= pin[0];
    irq1 <= pin[0];
    wr(t ? ADDR_CLO_ONE : ADDR_CLO_ZERO, 8'(lo));
    wr(t ? ADDR_CHI_ONE : ADDR_CHI_ZERO, 8'(hi));
    wr(ADDR_CTRL_FLAG, t ? 8'h40 : 8'h10);
    n_ev  <= 4'(n);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (2) @(posedge clk);
    for (int k = 0; k < 200 && busy; k++) @(posedge clk);
    repeat (4) @(posedge clk);
    for (int k = 0; k < n && (g == 0 || pin == 1); k++)
    begin
      r  = step(md, el, eh);
      el = r & 255;
      eh = (r >> 8) & 255;
      ov = ov | (r >> 16);
    end
    rchk(ADDR_CTRL_FLAG, t ? 8'(ov * 128 + 64) : 8'(ov * 32 + 16));
    // raise the ack on an edge, held for exactly one sampling edge
    @(posedge clk);
    ack0 <= !t[0];
    ack1 <= t[0];
    @(posedge clk);
    ack0 <= 1'b0;
    ack1 <= 1'b0;
    #1 chk({6'h0, f1, f0}, 8'h00);
    wr(ADDR_CTRL_FLAG, 8'h00);
    rchk(t ? ADDR_CLO_ONE : ADDR_CLO_ZERO, 8'(el));
    rchk(t ? ADDR_CHI_ONE : ADDR_CHI_ZERO, 8'(eh));
  endtask : ev_test
  // reload from 0xff wraps every tick, so pulse spacing is the tick period
  task automatic rate_test(input int t, rb);
    int k;
    wr(ADDR_MODE, t ? 8'h20 : 8'h02);
    wr(ADDR_RATE, 8'(rb * (t ? 16 : 8)));
    wr(t ? ADDR_CLO_ONE : ADDR_CLO_ZERO, 8'hff);
    wr(t ? ADDR_CHI_ONE : ADDR_CHI_ZERO, 8'hff);
    wr(ADDR_CTRL_FLAG, t ? 8'h40 : 8'h10);
    #1;
    for (k = 0; k < 50 && !(t ? p1 : p0); k++) @(posedge clk) #1;
    k = 0;
    do
    begin
      @(posedge clk);
      #1 k++;
    end
    while (!(t ? p1 : p0) && k < 50);
    chk(8'(k), rb ? 8'h04 : 8'h0c);
    wr(ADDR_CTRL_FLAG, 8'h00);
  endtask : rate_test
  // ========================================================================
  // main sequence
  initial
  begin
    {rst, we, re, ack0, ack1, start, slow, tsel} = 8'h80;
    {irq0, irq1, addr, wd, n_ev} = {2'h3, 20'h0};
    {failures, comparisons, cyc} = {32'h0, 32'h0, 32'h0};
    void'($urandom(79356));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int a = 'h87; a <= 'h8f; a++) rchk(8'(a), a == 'h8e ? RST_RATE : READ_ZERO);
    wr(ADDR_CTRL_FLAG, 8'hff);
    rchk(ADDR_CTRL_FLAG, 8'hf0);
    wr(ADDR_CTRL_FLAG, 8'h00);
    for (int a = 'h89; a <= 'h8d; a++)
    begin
      v = 8'($urandom);
      wr(8'(a), v);
      rchk(8'(a), v);
    end
    ev_test(0, 1, 0, 0, 'hfe, 'hff, 3);
    ev_test(0, 0, 1, 1, 'hfe, 'hff, 3);
    ev_test(0, 2, 1, 0, $urandom % 256, $urandom % 256, 3);
    ev_test(1, 2, 0, 0, 'hfd, 'h80, 5);
    ev_test(1, 1, 1, 1, $urandom % 256, $urandom % 256, 4);
    ev_test(1, 0, 1, 0, $urandom % 256, $urandom % 256, 3);
    ev_test(1, 3, 0, 1, $urandom % 256, $urandom % 256, 3);
    for (int t = 0; t < 4; t++) rate_test(t / 2, t % 2);
    wr(ADDR_MODE, 8'h33);
    wr(ADDR_RATE, 8'h08);
    wr(ADDR_CLO_ONE, 8'h5a);
    wr(ADDR_CHI_ZERO, 8'hfe);
    wr(ADDR_CTRL_FLAG, 8'h40);
    for (int k = 0; k < 12 && !f1; k++) @(posedge clk);
    #1 chk({6'h0, f1, f0}, 8'h02);
    wr(ADDR_CTRL_FLAG, 8'h00);
    rchk(ADDR_CLO_ONE, 8'h5a);
    end_sim();
  end
endmodule : tb_dual_timer_counter_modes
